// file: design/bvc_map.vh
`ifndef BVC_MAP_VH
`define BVC_MAP_VH
// configuration dword byte offsets
`define BVC_OFF_DIAG1      8'hc4
`define BVC_OFF_DIAG2      8'hc8
`define BVC_OFF_SUBSYS     8'hd0
`define BVC_OFF_GENCTL     8'hd4
// reset values
`define BVC_RST_DIAG1      32'h00120108
`define BVC_RST_DIAG2      32'h32142000
`define BVC_RST_SUBSYS     32'h00000000
`define BVC_RST_GENCTL     32'h8600025f
// writable bit masks
`define BVC_WMASK_DIAG1    32'h001fffff
`define BVC_WMASK_DIAG2    32'hffff1fbf
`define BVC_WMASK_GENCTL   32'hfeffffff
// field positions
`define BVC_IDLE_TMR_HI    5
`define BVC_IDLE_TMR_LO    2
`define BVC_LAT_SEP_HI     20
`define BVC_LAT_SEP_LO     18
`define BVC_LAT_SHR_HI     17
`define BVC_LAT_SHR_LO     15
`define BVC_FTS_SEP_HI     31
`define BVC_FTS_SEP_LO     24
`define BVC_FTS_SHR_HI     23
`define BVC_FTS_SHR_LO     16
`define BVC_LAYER_REV_HI   15
`define BVC_LAYER_REV_LO   13
`define BVC_LINK_NUM_HI    12
`define BVC_LINK_NUM_LO    8
`define BVC_L2_SAVE_BIT    7
`define BVC_BAR_EN_BIT     5
`endif

// file: design/bvc_regs.v
// Operation
// - diag one bits 5:2 hold the read/write idle entry timer in 62.5 MHz ticks, reset 0010b.
// - with the shared clock bit clear, the separate-clock fast train count in 31:24 is sent.
// - with the shared clock bit set, the shared-clock fast train count in 23:16 is sent.
// - deep sleep power saving applies only while bit 7 of diag two is 1.
// - bit 6 of diag two reads 0 and ignores writes.
// - the base window at offset 10h is enabled only while diag two bit 5 is 1, off at reset.
// - bits 31:16 written to the alias register appear as the board product ident at 46h.
// - bits 15:0 written to the alias register appear as the board maker ident at 44h.
// - general control resets to 8600025fh and mixes read-only and read/write fields.
// - the sleep exit latency mirrored into link capabilities is chosen by the shared clock bit.
`timescale 1ns/1ns
`include "bvc_map.vh"
module bvc_regs #(
  // revision code, value is arbitrary
  parameter [2:0] PHY_REVISION = 3'h1
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [7:0]  cfg_addr,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  output reg  [31:0] cfg_rdata,
  output reg         cfg_rvalid,
  input  wire        shared_clock_config_bit,
  output reg  [7:0]  fast_train_count,
  output reg  [2:0]  sleep_exit_latency,
  output reg  [3:0]  idle_entry_timer,
  output reg  [4:0]  link_number,
  output reg         deep_sleep_power_save_enable,
  output reg         first_base_window_enable,
  output reg  [15:0] board_product_ident,
  output reg  [15:0] board_maker_ident,
  output reg  [31:0] general_control
);

  localparam LANES = 4;

  reg  [31:0] diag1_r;
  reg  [31:0] diag2_r;
  reg  [31:0] subsys_r;
  reg  [31:0] genctl_r;
  reg         shclk_s1_r;
  reg         shclk_s2_r;
  wire        hit_diag1;
  wire        hit_diag2;
  wire        hit_subsys;
  wire        hit_genctl;
  wire [31:0] diag1_nxt;
  wire [31:0] diag2_nxt;
  wire [31:0] subsys_nxt;
  wire [31:0] genctl_nxt;
  wire [31:0] wmask_diag1;
  wire [31:0] wmask_diag2;
  wire [31:0] wmask_genctl;
  wire [31:0] diag1_view;
  wire [31:0] diag2_view;
  wire [31:0] genctl_view;
  reg  [31:0] rd_nxt;
  reg  [7:0]  fts_nxt;
  reg  [2:0]  lat_nxt;
  genvar      lane;

  // offset decode
  assign hit_diag1  = (cfg_addr == `BVC_OFF_DIAG1);
  assign hit_diag2  = (cfg_addr == `BVC_OFF_DIAG2);
  assign hit_subsys = (cfg_addr == `BVC_OFF_SUBSYS);
  assign hit_genctl = (cfg_addr == `BVC_OFF_GENCTL);

  // writable bits, the rest are read-only
  assign wmask_diag1  = `BVC_WMASK_DIAG1;
  assign wmask_diag2  = `BVC_WMASK_DIAG2;
  assign wmask_genctl = `BVC_WMASK_GENCTL;

  // read-only bits read zero, revision shown in diag two
  assign diag1_view  = diag1_r & wmask_diag1;
  assign diag2_view  = {diag2_r[31:16], PHY_REVISION, diag2_r[12:7], 1'b0, diag2_r[5:0]};
  assign genctl_view = genctl_r & wmask_genctl;

  // per byte lane write merge
  generate
    for (lane = 0; lane < LANES; lane = lane + 1)
    begin : g_lane
      wire       lane_wr;
      wire [7:0] wd;
      wire [7:0] wm_d1;
      wire [7:0] wm_d2;
      wire [7:0] wm_gc;
      wire [7:0] cur_d1;
      wire [7:0] cur_d2;
      wire [7:0] cur_ss;
      wire [7:0] cur_gc;
      assign lane_wr = cfg_wr & cfg_be[lane];
      assign wd      = cfg_wdata[8*lane +: 8];
      assign wm_d1   = wmask_diag1[8*lane +: 8];
      assign wm_d2   = wmask_diag2[8*lane +: 8];
      assign wm_gc   = wmask_genctl[8*lane +: 8];
      assign cur_d1  = diag1_r[8*lane +: 8];
      assign cur_d2  = diag2_r[8*lane +: 8];
      assign cur_ss  = subsys_r[8*lane +: 8];
      assign cur_gc  = genctl_r[8*lane +: 8];
      assign diag1_nxt[8*lane +: 8] = (lane_wr & hit_diag1) ?
        ((cur_d1 & ~wm_d1) | (wd & wm_d1)) : cur_d1;
      assign diag2_nxt[8*lane +: 8] = (lane_wr & hit_diag2) ?
        ((cur_d2 & ~wm_d2) | (wd & wm_d2)) : cur_d2;
      assign subsys_nxt[8*lane +: 8] = (lane_wr & hit_subsys) ?
        wd : cur_ss;
      assign genctl_nxt[8*lane +: 8] = (lane_wr & hit_genctl) ?
        ((cur_gc & ~wm_gc) | (wd & wm_gc)) : cur_gc;
    end
  endgenerate

  // register update, every clock
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      diag1_r  <= `BVC_RST_DIAG1;
      diag2_r  <= `BVC_RST_DIAG2;
      subsys_r <= `BVC_RST_SUBSYS;
      genctl_r <= `BVC_RST_GENCTL;
    end
    else
    begin
      diag1_r  <= diag1_nxt;
      diag2_r  <= diag2_nxt;
      subsys_r <= subsys_nxt;
      genctl_r <= genctl_nxt;
    end
  end

  // read mux, unmapped offsets read zero
  always @*
  begin
    rd_nxt = 32'h00000000;
    if (cfg_addr == `BVC_OFF_DIAG1)
      rd_nxt = diag1_view;
    else if (cfg_addr == `BVC_OFF_DIAG2)
      rd_nxt = diag2_view;
    else if (cfg_addr == `BVC_OFF_SUBSYS)
      rd_nxt = subsys_r;
    else if (cfg_addr == `BVC_OFF_GENCTL)
      rd_nxt = genctl_view;
  end

  // registered read answer
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cfg_rdata  <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_rd;
      cfg_rdata  <= cfg_rd ? rd_nxt : 32'h00000000;
    end
  end

  // shared clock bit arrives from link control
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      shclk_s1_r <= 1'b0;
      shclk_s2_r <= 1'b0;
    end
    else
    begin
      shclk_s1_r <= shared_clock_config_bit;
      shclk_s2_r <= shclk_s1_r;
    end
  end

  // mirrored fields follow the synchronised shared clock bit
  always @*
  begin
    fts_nxt = diag2_r[`BVC_FTS_SEP_HI:`BVC_FTS_SEP_LO];
    lat_nxt = diag1_r[`BVC_LAT_SHR_HI:`BVC_LAT_SHR_LO];
    if (shclk_s2_r)
    begin
      fts_nxt = diag2_r[`BVC_FTS_SHR_HI:`BVC_FTS_SHR_LO];
      lat_nxt = diag1_r[`BVC_LAT_SEP_HI:`BVC_LAT_SEP_LO];
    end
  end

  // registered field outputs, one cycle behind the registers
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      fast_train_count             <= 8'h00;
      sleep_exit_latency           <= 3'h0;
      idle_entry_timer             <= 4'h0;
      link_number                  <= 5'h00;
      deep_sleep_power_save_enable <= 1'b0;
      first_base_window_enable     <= 1'b0;
      board_product_ident          <= 16'h0000;
      board_maker_ident            <= 16'h0000;
      general_control              <= 32'h00000000;
    end
    else
    begin
      fast_train_count             <= fts_nxt;
      sleep_exit_latency           <= lat_nxt;
      idle_entry_timer             <= diag1_r[`BVC_IDLE_TMR_HI:`BVC_IDLE_TMR_LO];
      link_number                  <= diag2_r[`BVC_LINK_NUM_HI:`BVC_LINK_NUM_LO];
      deep_sleep_power_save_enable <= diag2_r[`BVC_L2_SAVE_BIT];
      first_base_window_enable     <= diag2_r[`BVC_BAR_EN_BIT];
      board_product_ident          <= subsys_r[31:16];
      board_maker_ident            <= subsys_r[15:0];
      general_control              <= genctl_r;
    end
  end

endmodule // bvc_regs

// file: test/bvc_regs_props.sv
`timescale 1ns/1ns
module bvc_regs_props (
  input wire        mclk,
  input wire        rst_n,
  input wire        cfg_rd,
  input wire [7:0]  cfg_addr,
  input wire [31:0] cfg_rdata,
  input wire        cfg_rvalid,
  input wire        shared_clock_config_bit,
  input wire [7:0]  fast_train_count,
  input wire        deep_sleep_power_save_enable,
  input wire        first_base_window_enable
);
  reg  [7:0] addr_r;
  wire       s = shared_clock_config_bit;
  wire       d2 = cfg_rvalid && addr_r == 8'hc8;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  always @(posedge mclk)
    addr_r <= cfg_addr;
  a_read_answer: assert property (cfg_rd |=> cfg_rvalid)
    else $error("no answer");
  a_answer_cause: assert property (cfg_rvalid |-> $past(cfg_rd))
    else $error("stray answer");
  a_rdata_idle: assert property (!cfg_rvalid |-> cfg_rdata == 32'h0)
    else $error("rdata not idle");
  a_bit6_zero: assert property (d2 |-> !cfg_rdata[6])
    else $error("bit6 set");
  a_fts_shared: assert property (d2 && $past(s,2) && $past(s,3) && $past(s,4)
    |-> fast_train_count == cfg_rdata[23:16]) else $error("fts shared");
  a_fts_separate: assert property (d2 && !$past(s,2) && !$past(s,3) && !$past(s,4)
    |-> fast_train_count == cfg_rdata[31:24]) else $error("fts separate");
  a_l2_save: assert property (d2 |-> deep_sleep_power_save_enable == cfg_rdata[7])
    else $error("l2 save");
  a_bar_enable: assert property (d2 |-> first_base_window_enable == cfg_rdata[5])
    else $error("bar enable");
endmodule // bvc_regs_props
bind bvc_regs bvc_regs_props i_bvc_regs_props (.mclk, .rst_n, .cfg_rd, .cfg_addr, .cfg_rdata,
  .cfg_rvalid, .shared_clock_config_bit, .fast_train_count, .deep_sleep_power_save_enable,
  .first_base_window_enable);

// file: test/bvc_regs_tb.sv
`timescale 1ns/1ns
module bvc_regs_tb;
  reg         mclk = 0, rst_n = 0, wr = 0, rd = 0, scb = 0;
  reg  [7:0]  addr = 8'h00;
  reg  [3:0]  be = 4'h0;
  reg  [31:0] wd = 32'h0;
  wire [31:0] rdata, gc;
  wire [15:0] pid, mid;
  wire [7:0]  fts;
  wire [4:0]  ln;
  wire [3:0]  tmr;
  wire [2:0]  lat;
  wire        rv, l2, bar;
  integer     failures = 0, check_count = 0, cyc = 0;
  bvc_regs i_bvc_regs (.mclk(mclk), .rst_n(rst_n), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr),
    .cfg_be(be), .cfg_wdata(wd), .cfg_rdata(rdata), .cfg_rvalid(rv),
    .shared_clock_config_bit(scb), .fast_train_count(fts), .sleep_exit_latency(lat),
    .idle_entry_timer(tmr), .link_number(ln), .deep_sleep_power_save_enable(l2),
    .first_base_window_enable(bar), .board_product_ident(pid), .board_maker_ident(mid),
    .general_control(gc));
  initial forever #5 mclk = ~mclk;
  task chk(input string n, input [32:0] s, input [32:0] e);
    begin
      check_count = check_count + 1;
      if (s !== e)
      begin
        failures = failures + 1;
        $display("mismatch %s exp %h seen %h", n, e, s);
      end
    end
  endtask
  task wt(input [7:0] a, input [3:0] b, input [31:0] d);
    begin
      @(negedge mclk);
      {wr, addr, be, wd} = {1'b1, a, b, d};
      @(negedge mclk);
      wr = 0;
    end
  endtask
  task rt(input [7:0] a, input [31:0] e);
    begin
      @(negedge mclk);
      {rd, addr} = {1'b1, a};
      @(negedge mclk);
      rd = 0;
      chk("read", {rv, rdata}, {1'b1, e});
    end
  endtask
  task summarize;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      failures = failures + 1;
      summarize;
    end
  end
  initial
  begin
    repeat (16) @(negedge mclk);
    rst_n = 1;
    rt(8'hc4, 32'h00120108);
    rt(8'hc8, 32'h32142000);
    rt(8'hd0, 32'h00000000);
    rt(8'hd4, 32'h8600025f);
    chk("tmr", tmr, 4'h2);
    chk("fts", fts, 8'h32);
    chk("bar", bar, 1'b0);
    chk("gc", gc, 32'h8600025f);
    chk("link", ln, 5'h00);
    chk("lat", lat, 3'h4);
    wt(8'hc8, 4'hf, 32'hffffffe0);
    rt(8'hc8, 32'hffff3fa0);
    chk("bar", bar, 1'b1);
    wt(8'hc8, 4'hf, 32'h12345660);
    wt(8'hc4, 4'hf, 32'h0005003c);
    wt(8'hc8, 4'h1, 32'h000000a0);
    rt(8'hc8, 32'h123436a0);
    rt(8'hc4, 32'h0005003c);
    chk("l2", l2, 1'b1);
    chk("tmr", tmr, 4'hf);
    chk("fts", fts, 8'h12);
    chk("lat", lat, 3'h2);
    chk("link", ln, 5'h16);
    scb = 1;
    wt(8'hc8, 4'h1, 32'h00000020);
    repeat (4) @(negedge mclk);
    rt(8'hc8, 32'h12343620);
    chk("fts", fts, 8'h34);
    chk("lat", lat, 3'h1);
    chk("l2", l2, 1'b0);
    wt(8'hd0, 4'hf, 32'h12345678);
    rt(8'hd0, 32'h12345678);
    chk("ids", {pid, mid}, 33'h12345678);
    wt(8'hd4, 4'hf, 32'hffffffff);
    rt(8'hd4, 32'hfeffffff);
    chk("gc", gc, 32'hfeffffff);
    wt(8'hc8, 4'hf, 32'h32142000);
    rt(8'hc8, 32'h32142000);
    chk("fts", fts, 8'h14);
    summarize;
  end
endmodule // bvc_regs_tb
